// File: hw/dcpc_defines.vh
`ifndef DCPC_DEFINES_VH
`define DCPC_DEFINES_VH
// ==========================================================
// register byte offsets
`define DCPC_OFF_CTRL      12'h000
`define DCPC_OFF_START     12'h004
`define DCPC_OFF_END       12'h008
`define DCPC_OFF_STATUS    12'h00C
`define DCPC_OFF_MASK      12'h010
`define DCPC_OFF_CMD       12'h014
`define DCPC_OFF_RATIO     12'h018
`define DCPC_OFF_C0LO      12'h020
`define DCPC_OFF_C0HI      12'h024
`define DCPC_OFF_C1LO      12'h028
`define DCPC_OFF_C1HI      12'h02C
`define DCPC_OFF_BRKA      12'h030
// ==========================================================
// ctrl fields, per channel byte: [0] enable [1] range [2] weighted [7:3] event
`define DCPC_CTL_EN        0
`define DCPC_CTL_RANGE     1
`define DCPC_CTL_WEIGHT    2
`define DCPC_CTL_EVLO      3
`define DCPC_CTL_EVHI      7
`define DCPC_CH_STRIDE     8
// ==========================================================
// ratio codes and weighted steps
`define DCPC_RATIO_W       3
`define DCPC_STEP_3        6'h03
`define DCPC_STEP_4        6'h04
`define DCPC_STEP_6        6'h06
`define DCPC_STEP_8        6'h08
`define DCPC_STEP_12       6'h0C
`define DCPC_STEP_24       6'h18
`define DCPC_STEP_1        6'h01
// ==========================================================
// misc
`define DCPC_CNT_W         48
`define DCPC_EV_W          32
`define DCPC_EV_TIME       5'h1F
`define DCPC_CMD_INIT      0
`define DCPC_ST_OVF0       0
`define DCPC_ST_OVF1       1
`define DCPC_ST_BRKLOST    2
`define DCPC_ST_W          3
`define DCPC_ZERO32        32'h00000000
`endif

// File: hw/dcpc_channel.v
`timescale 1ns/1ps
`include "dcpc_defines.vh"
// one 48-bit measurement channel
module dcpc_channel (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    clk_en,
    input  wire                    clear,      // init command
    input  wire                    hit,        // counted condition this cycle
    input  wire                    weighted,
    input  wire [5:0]              step_w,     // weighted step
    output reg  [`DCPC_CNT_W-1:0]  count_reg,
    output reg                     ovf_pulse
);
    wire [5:0]             step  = weighted ? step_w : `DCPC_STEP_1;
    wire [`DCPC_CNT_W:0]   sum   = {1'b0, count_reg} + {{(`DCPC_CNT_W-5){1'b0}}, step};

    // ==========================================================
    // counter; carry out marks overflow
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= {`DCPC_CNT_W{1'b0}};
            ovf_pulse <= 1'b0;
        end else if (clk_en) begin
            ovf_pulse <= 1'b0;
            if (clear) begin
                count_reg <= {`DCPC_CNT_W{1'b0}};
            end else if (hit) begin
                count_reg <= sum[`DCPC_CNT_W-1:0];
                ovf_pulse <= sum[`DCPC_CNT_W];
            end
        end
    end
endmodule

// File: hw/dcpc_top.v
`timescale 1ns/1ps
`include "dcpc_defines.vh"
// ==========================================================
// Summary of operation
// - per channel, whole run or address window
// - per channel, plain or ratio-weighted counting
// - plain mode adds one per counted cycle
// - weighted step 3..24 from clock ratio
// - counters are 48 bits wide
// - wrap sets sticky overflow, count invalid
// - shared comparators keep last written values
// - loading window overwrites break comparator setting
// - host reprograms break comparisons afterwards
// - init clears counts and overflow flags
module dcpc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        run_in,         // program running, async pin
    input  wire [31:0] pc_in,          // current pc, same clock
    input  wire [31:0] event_in,       // event strobes, same clock
    output reg         irq,
    output reg         brk_match       // break compare hit
);
    // ==========================================================
    // registers
    reg  [15:0]            ctrl_reg;        // two channel bytes
    reg  [31:0]            start_reg;       // shared start compare
    reg  [31:0]            end_reg;         // shared end compare
    reg  [31:0]            brka_reg;        // break compare address
    reg  [`DCPC_ST_W-1:0]  status_reg;      // sticky events
    reg  [`DCPC_ST_W-1:0]  mask_reg;        // interrupt enables
    reg  [2:0]             ratio_reg;       // cpu/bus ratio code
    reg  [1:0]             win_reg;         // inside-window per channel
    reg                    run_s1_reg;      // synchroniser stage 1
    reg                    run_s2_reg;      // synchroniser stage 2
    reg                    use_brk_reg;     // break comparator owned by break use
    wire [`DCPC_CNT_W-1:0] cnt0;
    wire [`DCPC_CNT_W-1:0] cnt1;
    wire [1:0]             ovf;
    wire [1:0]             hit;

    // ==========================================================
    // apb decode; one wait state
    wire acc      = psel & penable & pready;
    wire wr       = acc & pwrite;
    wire wr_start = wr & (paddr == `DCPC_OFF_START);
    wire wr_end   = wr & (paddr == `DCPC_OFF_END);
    wire wr_brka  = wr & (paddr == `DCPC_OFF_BRKA);
    wire init     = wr & (paddr == `DCPC_OFF_CMD) & pwdata[`DCPC_CMD_INIT];

    // known-offset check, used for the error answer only
    function known;
        input [11:0] a;
        begin
            known = (a == `DCPC_OFF_CTRL)  | (a == `DCPC_OFF_START) |
                    (a == `DCPC_OFF_END)   | (a == `DCPC_OFF_STATUS) |
                    (a == `DCPC_OFF_MASK)  | (a == `DCPC_OFF_CMD) |
                    (a == `DCPC_OFF_RATIO) | (a == `DCPC_OFF_C0LO) |
                    (a == `DCPC_OFF_C0HI)  | (a == `DCPC_OFF_C1LO) |
                    (a == `DCPC_OFF_C1HI)  | (a == `DCPC_OFF_BRKA);
        end
    endfunction

    // ratio code to weighted step
    function [5:0] ratio_step;
        input [2:0] r;
        begin
            case (r)
                3'h0:    ratio_step = `DCPC_STEP_3;
                3'h1:    ratio_step = `DCPC_STEP_4;
                3'h2:    ratio_step = `DCPC_STEP_6;
                3'h3:    ratio_step = `DCPC_STEP_8;
                3'h4:    ratio_step = `DCPC_STEP_12;
                default: ratio_step = `DCPC_STEP_24;
            endcase
        end
    endfunction

    wire [5:0] step_w    = ratio_step(ratio_reg);
    wire       start_hit = (pc_in == start_reg);
    wire       end_hit   = (pc_in == end_reg);

    // ==========================================================
    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg    <= 16'h0000;
            start_reg   <= 32'h00000000;
            end_reg     <= 32'h00000000;
            brka_reg    <= 32'h00000000;
            mask_reg    <= {`DCPC_ST_W{1'b0}};
            ratio_reg   <= 3'h0;
            use_brk_reg <= 1'b1;
        end else if (clk_en) begin
            if (wr & (paddr == `DCPC_OFF_CTRL))
                ctrl_reg <= pwdata[15:0];
            if (wr & (paddr == `DCPC_OFF_MASK))
                mask_reg <= pwdata[`DCPC_ST_W-1:0];
            if (wr & (paddr == `DCPC_OFF_RATIO))
                ratio_reg <= pwdata[2:0];
            // one pair of comparators; last write wins for both channels
            if (wr_start)
                start_reg <= pwdata;
            if (wr_end)
                end_reg <= pwdata;
            // window load takes the break comparator over
            if (wr_start | wr_end | init)
                use_brk_reg <= 1'b0;
            else if (wr_brka)
                use_brk_reg <= 1'b1;
            if (wr_brka)
                brka_reg <= pwdata;
        end
    end

    // ==========================================================
    // run pin synchroniser and window tracking
    genvar g;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_s1_reg <= 1'b0;
            run_s2_reg <= 1'b0;
        end else if (clk_en) begin
            run_s1_reg <= run_in;
            run_s2_reg <= run_s1_reg;
        end
    end

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            wire [7:0] c     = ctrl_reg[g*`DCPC_CH_STRIDE +: `DCPC_CH_STRIDE];
            wire [4:0] evsel = c[`DCPC_CTL_EVHI:`DCPC_CTL_EVLO];
            wire       ev    = (evsel == `DCPC_EV_TIME) ? 1'b1 : event_in[evsel];
            // window opens the cycle after start, closes at end
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    win_reg[g] <= 1'b0;
                end else if (clk_en) begin
                    if (init | end_hit)
                        win_reg[g] <= 1'b0;
                    else if (start_hit)
                        win_reg[g] <= 1'b1;
                end
            end
            // gating: range mode uses window, else whole run
            assign hit[g] = c[`DCPC_CTL_EN] & run_s2_reg & ev &
                            (c[`DCPC_CTL_RANGE] ? (win_reg[g] & ~end_hit) : 1'b1);
        end
    endgenerate

    dcpc_channel u_ch0 (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .clear     (init),
        .hit       (hit[0]),
        .weighted  (ctrl_reg[`DCPC_CTL_WEIGHT]),
        .step_w    (step_w),
        .count_reg (cnt0),
        .ovf_pulse (ovf[0])
    );

    dcpc_channel u_ch1 (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .clear     (init),
        .hit       (hit[1]),
        .weighted  (ctrl_reg[`DCPC_CH_STRIDE + `DCPC_CTL_WEIGHT]),
        .step_w    (step_w),
        .count_reg (cnt1),
        .ovf_pulse (ovf[1])
    );

    // ==========================================================
    // sticky status; set beats write-one clear, init clears all
    wire [`DCPC_ST_W-1:0] st_set = {wr_start | wr_end, ovf};
    wire [`DCPC_ST_W-1:0] st_clr = (wr & (paddr == `DCPC_OFF_STATUS)) ?
                                   pwdata[`DCPC_ST_W-1:0] : {`DCPC_ST_W{1'b0}};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= {`DCPC_ST_W{1'b0}};
        end else if (clk_en) begin
            if (init)
                status_reg <= {`DCPC_ST_W{1'b0}};
            else
                status_reg <= (status_reg & ~st_clr) | st_set;
        end
    end

    // ==========================================================
    // outputs, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            irq       <= 1'b0;
            brk_match <= 1'b0;
        end else if (clk_en) begin
            irq       <= |(status_reg & mask_reg);
            brk_match <= use_brk_reg & (pc_in == brka_reg);
            // answer one cycle into access phase
            pready    <= psel & penable & ~pready;
            pslverr   <= psel & penable & ~pready & ~known(paddr);
            if (psel & ~pwrite) begin
                case (paddr)
                    `DCPC_OFF_CTRL:   prdata <= {16'h0000, ctrl_reg};
                    `DCPC_OFF_START:  prdata <= start_reg;
                    `DCPC_OFF_END:    prdata <= end_reg;
                    `DCPC_OFF_STATUS: prdata <= {29'h0, status_reg};
                    `DCPC_OFF_MASK:   prdata <= {29'h0, mask_reg};
                    `DCPC_OFF_RATIO:  prdata <= {29'h0, ratio_reg};
                    `DCPC_OFF_C0LO:   prdata <= cnt0[31:0];
                    `DCPC_OFF_C0HI:   prdata <= {16'h0000, cnt0[47:32]};
                    `DCPC_OFF_C1LO:   prdata <= cnt1[31:0];
                    `DCPC_OFF_C1HI:   prdata <= {16'h0000, cnt1[47:32]};
                    `DCPC_OFF_BRKA:   prdata <= brka_reg;
                    default:          prdata <= `DCPC_ZERO32;
                endcase
            end
        end
    end
endmodule

// File: dv/dcpc_props.sv
`timescale 1ns/1ps
// ==========================================================
// port-level checks of the counter block
module dcpc_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq,
    input wire        brk_match
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================================
    // bus handshake: exactly one wait state, one-cycle answer
    property p_wait; $rose(penable) && psel |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("answer not after one wait state");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_acc; pready |-> psel && penable; endproperty
    a_acc: assert property (p_acc) else $error("ready outside access phase");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    // refused reads must not leak stale data
    property p_zero; pready && pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
    a_zero: assert property (p_zero) else $error("unmapped read not zero");
    // ==========================================================
    // window load takes the break comparator away
    property p_win;
        pready && pwrite && (paddr == 12'h004 || paddr == 12'h008) |-> ##2 !brk_match [*3];
    endproperty
    a_win: assert property (p_win) else $error("break hit after window load");
    property p_init;
        pready && pwrite && paddr == 12'h014 && pwdata[0] |-> ##2 !brk_match [*3];
    endproperty
    a_init: assert property (p_init) else $error("break hit after init");
    // init wipes status, so the line must drop
    property p_clr; pready && pwrite && paddr == 12'h014 && pwdata[0] |-> ##2 !irq; endproperty
    a_clr: assert property (p_clr) else $error("irq after init");
    property p_mask;
        pready && pwrite && paddr == 12'h010 && pwdata == 32'h00000000 |-> ##2 !irq;
    endproperty
    a_mask: assert property (p_mask) else $error("irq with all masked");
endmodule

// File: dv/dcpc_host.sv
`timescale 1ns/1ps
// ==========================================================
// debug host: apb master driving the counter registers
module dcpc_host (
    input  wire        pclk,
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg  [11:0] paddr,
    output reg  [31:0] pwdata,
    input  wire [31:0] prdata,
    input  wire        pready,
    input  wire        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end
    // one transfer; request held until ready is seen at an edge
    // only one window register pair exists, so both channels share it
    task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the two-channel counter
module tb_top;
    reg         pclk = 0, presetn = 0, run_in = 0, clk_en = 1;
    reg  [31:0] pc_in = 0, event_in = 0, q, a;
    reg         e;
    wire        psel, penable, pwrite, pready, pslverr, irq, brk_match;
    wire [11:0] paddr;
    wire [31:0] pwdata, prdata;
    integer     err_count = 0, checks = 0, seed = 32'hB82E40F1, n, m, k, r;
    always #50 pclk = ~pclk;
    dcpc_top dcpc_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .run_in(run_in), .pc_in(pc_in),
        .event_in(event_in), .irq(irq), .brk_match(brk_match));
    dcpc_host dcpc_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // ==========================================================
    // helpers
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [11:0] ad, input [31:0] d);
        dcpc_host_i.xfer(1'b1, ad, d, q, e);
    endtask
    task rdc(input [11:0] ad, input [31:0] exp, input ee);
        begin
            dcpc_host_i.xfer(1'b0, ad, 32'h00000000, q, e);
            chk(q, exp);
            chk({31'h0, e}, {31'h0, ee});
        end
    endtask
    // weighted step per ratio code
    function [31:0] step(input integer c);
        step = (c == 0) ? 3 : (c == 1) ? 4 : (c == 2) ? 6 : (c == 3) ? 8 : (c == 4) ? 12 : 24;
    endfunction
    // event high for exactly cnt sampled edges, then settle
    task pulse(input integer b, input integer cnt);
        begin
            @(posedge pclk) event_in[b] <= 1'b1;
            repeat (cnt) @(posedge pclk);
            event_in <= 32'h00000000;
            repeat (4) @(posedge pclk);
        end
    endtask
    task report_and_stop;
        begin
            if (err_count == 0 && checks > 0) $display("DONE - PASS");
            else $display("DONE - FAIL");
            $finish;
        end
    endtask
    // watchdog, far beyond the expected run
    initial begin
        #(30000 * 100);
        err_count = err_count + 1;
        report_and_stop;
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        run_in <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(12'hFFC, 32'h00000000, 1'b1);
        // ch0 plain, ch1 weighted on the same event, every ratio code
        for (r = 0; r < 8; r = r + 1) begin
            k = $unsigned($random(seed)) % 31;
            n = 1 + $unsigned($random(seed)) % 16;
            wr(12'h014, 1);
            wr(12'h018, r);
            wr(12'h000, ((((k << 3) | 5) << 8) | (k << 3) | 1));
            pulse(k, n);
            rdc(12'h020, n, 1'b0);
            rdc(12'h028, n * step(r), 1'b0);
            rdc(12'h02C, 0, 1'b0);
        end
        // ch0 windowed, ch1 whole run; last start value must win
        wr(12'h014, 1);
        a = $random(seed) | 32'h80000000;
        m = 2 + $unsigned($random(seed)) % 8;
        wr(12'h004, ~a);
        wr(12'h004, a);
        wr(12'h008, a + 4);
        wr(12'h000, ((((k << 3) | 1) << 8) | (k << 3) | 3));
        @(posedge pclk) event_in[k] <= 1'b1;
        repeat (3) @(posedge pclk);
        pc_in <= a;
        @(posedge pclk) pc_in <= 32'h00000000;
        repeat (m) @(posedge pclk);
        pc_in <= a + 4;
        @(posedge pclk) pc_in <= 32'h00000000;
        event_in <= 32'h00000000;
        repeat (4) @(posedge pclk);
        rdc(12'h020, m, 1'b0);
        rdc(12'h028, m + 5, 1'b0);
        // break compare, then taken over by a window load; irq path
        wr(12'h030, a);
        pc_in <= a;
        repeat (3) @(posedge pclk);
        chk({31'h0, brk_match}, 1);
        wr(12'h010, 4);
        wr(12'h004, a);
        repeat (3) @(posedge pclk);
        chk({31'h0, brk_match}, 0);
        rdc(12'h00C, 4, 1'b0);
        chk({31'h0, irq}, 1);
        wr(12'h010, 0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0);
        wr(12'h010, 4);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 1);
        wr(12'h00C, 4);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 0);
        // init clears counts and status
        wr(12'h014, 1);
        rdc(12'h028, 0, 1'b0);
        rdc(12'h00C, 0, 1'b0);
        // enable low freezes counting even with the event high
        clk_en <= 1'b0;
        pulse(k, 3);
        clk_en <= 1'b1;
        rdc(12'h028, 0, 1'b0);
        report_and_stop;
    end
endmodule
bind dcpc_top dcpc_props dcpc_props_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .brk_match(brk_match));
